// *** hdl/scs_axis.sv ***
/*
 * One axis of current reduce, windings-off and standstill band control.
 * Assumes moveStart and lastStep are one-cycle pulses from the step
 * generator, synchronous to core_clk, and positions in the same units.
 */
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_axis (
    // Clock and reset.
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // Motion events.
    input  wire logic               moveStart,
    input  wire logic               lastStep,
    // Settings.
    input  wire logic               reduceEn,
    input  wire logic               windSet,
    input  wire logic               loopEn,
    input  wire scs_pkg::scs_word_t band,
    // Positions.
    input  wire scs_pkg::scs_word_t cmdPos,
    input  wire scs_pkg::scs_word_t encPos,
    // Drive and status outputs.
    output logic                    reduceOut,
    output logic                    windOff,
    output logic                    corrStart,
    output scs_pkg::scs_word_t      corrDist,
    output scs_pkg::scs_word_t      posErr,
    output logic [2:0]              axisStat
);
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // Error magnitude.
    // ------------------------------------------------------------------
    function automatic scs_word_t magnitude(input scs_word_t v);
        magnitude = v[`SCS_DATA_W-1] ? scs_word_t'(~v + 32'h0000_0001) : v;
    endfunction

    scs_axis_e state_reg;
    scs_axis_e state_next;
    logic      reduce_reg;
    logic      wind_reg;
    logic      corr_reg;
    logic      over_reg;
    scs_word_t dist_reg;
    scs_word_t err_reg;
    scs_word_t errNow;
    logic      overNow;
    logic      trigger;
    logic      idleNext;

    // Signed error, compared by magnitude so either sign triggers.
    assign errNow   = cmdPos - encPos;
    assign overNow  = magnitude(errNow) > band;
    // A pending move start wins over a correction in the same cycle.
    assign trigger  = (state_reg == SCS_IDLE) & loopEn & overNow
                      & ~moveStart;
    assign idleNext = (state_next == SCS_IDLE);

    // ------------------------------------------------------------------
    // Activity: busy from the move start until its last step.
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCS_IDLE: begin
                if (moveStart) begin
                    state_next = SCS_MOVE;
                end else if (trigger) begin
                    state_next = SCS_CORR;
                end
            end
            SCS_MOVE, SCS_CORR: begin
                if (lastStep) begin
                    state_next = SCS_IDLE;
                end
            end
            default: state_next = SCS_IDLE;
        endcase
    end

    // State and drive outputs, updated on the same edge as activity.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= SCS_IDLE;
            reduce_reg <= `SCS_RST_FLAG;
            wind_reg   <= `SCS_RST_FLAG;
            corr_reg   <= `SCS_RST_FLAG;
            over_reg   <= `SCS_RST_FLAG;
        end else begin
            state_reg  <= state_next;
            reduce_reg <= reduceEn & idleNext;
            wind_reg   <= idleNext ? windSet : wind_reg;
            corr_reg   <= trigger;
            over_reg   <= overNow;
        end
    end

    // Correction distance is frozen at the trigger; error is sampled.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dist_reg <= `SCS_RST_WORD;
            err_reg  <= `SCS_RST_WORD;
        end else begin
            dist_reg <= trigger ? errNow : dist_reg;
            err_reg  <= errNow;
        end
    end

    assign reduceOut = reduce_reg;
    assign windOff   = wind_reg;
    assign corrStart = corr_reg;
    assign corrDist  = dist_reg;
    assign posErr    = err_reg;
    assign axisStat  = {state_reg == SCS_CORR, over_reg, state_reg != SCS_IDLE};

endmodule // scs_axis

// *** hdl/scs_consts.svh ***
/*
 * Constants of the stepper current and standstill control block: register
 * groups, field positions, reset values and bus answer codes.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// ----------------------------------------------------------------------
// Geometry.
// ----------------------------------------------------------------------
`define SCS_AXES        8
`define SCS_ADDR_W      8
`define SCS_DATA_W      32

// ----------------------------------------------------------------------
// Register groups: byte address = group * 0x20 + axis index * 4.
// ----------------------------------------------------------------------
`define SCS_GRP_REDUCE  3'h0
`define SCS_GRP_WIND    3'h1
`define SCS_GRP_BAND    3'h2
`define SCS_GRP_LOOP    3'h3
`define SCS_GRP_STAT    3'h4
`define SCS_GRP_PERR    3'h5

// ----------------------------------------------------------------------
// Status word field positions.
// ----------------------------------------------------------------------
`define SCS_STAT_MOVING 0
`define SCS_STAT_REDUCE 1
`define SCS_STAT_WIND   2
`define SCS_STAT_OVER   3
`define SCS_STAT_CORR   4

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define SCS_RST_FLAG    1'b0
`define SCS_RST_BAND    32'h0000_0000
`define SCS_RST_WORD    32'h0000_0000

// ----------------------------------------------------------------------
// AXI4-Lite response codes.
// ----------------------------------------------------------------------
`define SCS_RESP_OKAY   2'h0
`define SCS_RESP_SLVERR 2'h2

`endif

// *** hdl/scs_ctrl.sv ***
/*
 * Eight-axis stepper current reduce, windings-off and standstill band
 * controller with an AXI4-Lite register slave.
 * Assumes one core clock, inputs synchronous to it, and a step generator
 * that pulses moveStart and lastStep and steps corrDist on corrStart.
 */
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_ctrl (
    // Clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    // AXI4-Lite write address.
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire scs_pkg::scs_addr_t       awaddr,
    input  wire logic [2:0]               awprot,
    // AXI4-Lite write data.
    input  wire logic                     wvalid,
    output logic                          wready,
    input  wire scs_pkg::scs_word_t       wdata,
    input  wire logic [3:0]               wstrb,
    // AXI4-Lite write response.
    output logic                          bvalid,
    input  wire logic                     bready,
    output logic [1:0]                    bresp,
    // AXI4-Lite read address.
    input  wire logic                     arvalid,
    output logic                          arready,
    input  wire scs_pkg::scs_addr_t       araddr,
    input  wire logic [2:0]               arprot,
    // AXI4-Lite read data.
    output logic                          rvalid,
    input  wire logic                     rready,
    output scs_pkg::scs_word_t            rdata,
    output logic [1:0]                    rresp,
    // Motion events per axis, bit 0 is axis 1.
    input  wire logic [`SCS_AXES-1:0]     moveStart,
    input  wire logic [`SCS_AXES-1:0]     lastStep,
    // Positions per axis, axis 1 in the low word.
    input  wire logic [8*`SCS_DATA_W-1:0] cmdPos,
    input  wire logic [8*`SCS_DATA_W-1:0] encPos,
    // Drive outputs per axis.
    output logic [`SCS_AXES-1:0]          reduceOut,
    output logic [`SCS_AXES-1:0]          windOff,
    output logic [`SCS_AXES-1:0]          corrStart,
    output logic [8*`SCS_DATA_W-1:0]      corrDist
);
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // Address decode helpers.
    // ------------------------------------------------------------------
    function automatic logic [2:0] groupOf(input scs_addr_t a);
        groupOf = a[7:5];
    endfunction

    function automatic logic [2:0] axisOf(input scs_addr_t a);
        axisOf = a[4:2];
    endfunction

    function automatic logic isMapped(input scs_addr_t a);
        isMapped = (groupOf(a) <= `SCS_GRP_PERR);
    endfunction

    function automatic logic isWritable(input scs_addr_t a);
        isWritable = (groupOf(a) <= `SCS_GRP_LOOP);
    endfunction

    function automatic scs_word_t laneMask(input logic [3:0] s);
        laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    logic [`SCS_AXES-1:0] reduceEn_reg;
    logic [`SCS_AXES-1:0] windSet_reg;
    logic [`SCS_AXES-1:0] loopEn_reg;
    scs_word_t            band_reg [`SCS_AXES];
    scs_word_t            posErr   [`SCS_AXES];
    logic [2:0]           axisStat [`SCS_AXES];

    logic                 awHeld_reg;
    scs_addr_t            awAddr_reg;
    logic                 wHeld_reg;
    scs_word_t            wData_reg;
    logic [3:0]           wStrb_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 rvalid_reg;
    scs_word_t            rdata_reg;
    logic [1:0]           rresp_reg;

    // ------------------------------------------------------------------
    // Write channel decode.
    // ------------------------------------------------------------------
    // Address and data are caught independently and the write happens
    // once both are held, so either may arrive first.
    wire        awTake   = awvalid & awready;
    wire        wTake    = wvalid & wready;
    wire        doWrite  = awHeld_reg & wHeld_reg & ~bvalid_reg;
    wire [2:0]  wrGroup  = groupOf(awAddr_reg);
    wire [2:0]  wrAxis   = axisOf(awAddr_reg);
    wire        wrOk     = isWritable(awAddr_reg);
    wire        anyLane  = |wStrb_reg;
    wire        wrMasked = |(wData_reg & laneMask(wStrb_reg));
    wire        wrFlag   = doWrite & wrOk & anyLane;
    wire        wrReduce = wrFlag & (wrGroup == `SCS_GRP_REDUCE);
    wire        wrWind   = wrFlag & (wrGroup == `SCS_GRP_WIND);
    wire        wrLoop   = wrFlag & (wrGroup == `SCS_GRP_LOOP);
    wire        wrBand   = doWrite & wrOk & (wrGroup == `SCS_GRP_BAND);
    wire [1:0]  wrResp   = wrOk ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;

    assign awready = ~awHeld_reg & ~bvalid_reg;
    assign wready  = ~wHeld_reg & ~bvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;

    // Write address and data holding registers.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wHeld_reg  <= 1'b0;
            wData_reg  <= `SCS_RST_WORD;
            wStrb_reg  <= 4'h0;
        end else begin
            awHeld_reg <= awTake | (awHeld_reg & ~doWrite);
            awAddr_reg <= awTake ? awaddr : awAddr_reg;
            wHeld_reg  <= wTake | (wHeld_reg & ~doWrite);
            wData_reg  <= wTake ? wdata : wData_reg;
            wStrb_reg  <= wTake ? wstrb : wStrb_reg;
        end
    end

    // Write response, held until the master takes it.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `SCS_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wrResp;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Per-axis settings.
    // ------------------------------------------------------------------
    // Flags store whether the written lanes hold any nonzero bit, so a
    // write of any true value enables and zero disables.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reduceEn_reg <= {`SCS_AXES{`SCS_RST_FLAG}};
            windSet_reg  <= {`SCS_AXES{`SCS_RST_FLAG}};
            loopEn_reg   <= {`SCS_AXES{`SCS_RST_FLAG}};
        end else begin
            if (wrReduce) begin
                reduceEn_reg[wrAxis] <= wrMasked;
            end
            if (wrWind) begin
                windSet_reg[wrAxis] <= wrMasked;
            end
            if (wrLoop) begin
                loopEn_reg[wrAxis] <= wrMasked;
            end
        end
    end

    // Band words merge byte lanes so partial writes keep other bytes.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `SCS_AXES; i++) begin
                band_reg[i] <= `SCS_RST_BAND;
            end
        end else if (wrBand) begin
            band_reg[wrAxis] <= (band_reg[wrAxis] & ~laneMask(wStrb_reg))
                              | (wData_reg & laneMask(wStrb_reg));
        end
    end

    // ------------------------------------------------------------------
    // Read channel.
    // ------------------------------------------------------------------
    wire        arTake  = arvalid & arready;
    wire [2:0]  rdGroup = groupOf(araddr);
    wire [2:0]  rdAxis  = axisOf(araddr);
    wire        rdOk    = isMapped(araddr);
    wire [2:0]  rdStat  = axisStat[rdAxis];
    wire [31:0] statWord = {27'h0000000, rdStat[2], rdStat[1],
                            windOff[rdAxis], reduceOut[rdAxis], rdStat[0]};
    wire [31:0] flagWord =
        {31'h00000000,
         (rdGroup == `SCS_GRP_REDUCE) ? reduceEn_reg[rdAxis] :
         (rdGroup == `SCS_GRP_WIND)   ? windSet_reg[rdAxis]  :
                                        loopEn_reg[rdAxis]};
    wire [31:0] rdWord =
        ~rdOk                        ? `SCS_RST_WORD      :
        (rdGroup == `SCS_GRP_BAND)   ? band_reg[rdAxis]   :
        (rdGroup == `SCS_GRP_STAT)   ? statWord           :
        (rdGroup == `SCS_GRP_PERR)   ? posErr[rdAxis]     :
                                       flagWord;

    assign arready = ~rvalid_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    // Read data is captured at the address handshake and held.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= `SCS_RST_WORD;
            rresp_reg  <= `SCS_RESP_OKAY;
        end else if (arTake) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rdWord;
            rresp_reg  <= rdOk ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Axis controllers.
    // ------------------------------------------------------------------
    // The correction move counts as motion, so a later lastStep ends it
    // and no second correction can start until then.
    for (genvar g = 0; g < `SCS_AXES; g++) begin : gAxis
        scs_axis uAxis (
            .core_clk  (core_clk),
            .rst_b     (rst_b),
            .moveStart (moveStart[g]),
            .lastStep  (lastStep[g]),
            .reduceEn  (reduceEn_reg[g]),
            .windSet   (windSet_reg[g]),
            .loopEn    (loopEn_reg[g]),
            .band      (band_reg[g]),
            .cmdPos    (cmdPos[g*`SCS_DATA_W +: `SCS_DATA_W]),
            .encPos    (encPos[g*`SCS_DATA_W +: `SCS_DATA_W]),
            .reduceOut (reduceOut[g]),
            .windOff   (windOff[g]),
            .corrStart (corrStart[g]),
            .corrDist  (corrDist[g*`SCS_DATA_W +: `SCS_DATA_W]),
            .posErr    (posErr[g]),
            .axisStat  (axisStat[g])
        );
    end

endmodule // scs_ctrl

// *** hdl/scs_pkg.sv ***
/*
 * Types shared by the stepper current and standstill control modules.
 * Assumes the constants header is on the include path.
 */
`include "scs_consts.svh"

package scs_pkg;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef logic [`SCS_DATA_W-1:0] scs_word_t;
    typedef logic [`SCS_ADDR_W-1:0] scs_addr_t;

    // Axis activity, Gray coded along idle, move, correction.
    typedef enum logic [1:0] {
        SCS_IDLE = 2'h0,
        SCS_MOVE = 2'h1,
        SCS_CORR = 2'h3
    } scs_axis_e;

endpackage

// *** verification/scs_ctrl_checker.sv ***
/*
 * Concurrent checks on the ports of the stepper control block.
 * Assumes it is bound to the top module, one clock domain.
 */
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_ctrl_checker (
    // Clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    // Register bus.
    input  wire logic                     awready,
    input  wire logic                     wready,
    input  wire logic                     bvalid,
    input  wire logic                     bready,
    input  wire logic [1:0]               bresp,
    input  wire logic                     arvalid,
    input  wire logic                     arready,
    input  wire logic                     rvalid,
    input  wire logic                     rready,
    input  wire scs_pkg::scs_word_t       rdata,
    // Axis side.
    input  wire logic [`SCS_AXES-1:0]     moveStart,
    input  wire logic [`SCS_AXES-1:0]     windOff,
    input  wire logic [8*`SCS_DATA_W-1:0] cmdPos,
    input  wire logic [8*`SCS_DATA_W-1:0] encPos,
    input  wire logic [`SCS_AXES-1:0]     reduceOut,
    input  wire logic [`SCS_AXES-1:0]     corrStart,
    input  wire logic [8*`SCS_DATA_W-1:0] corrDist
);
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // Properties.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    property p_aw_block;
        bvalid |-> !awready && !wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write not held");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
    property p_r_ans;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
    property p_red_drop;
        reduceOut[0] && moveStart[0] |=> !reduceOut[0];
    endproperty
    a_red_drop: assert property (p_red_drop) else $error("reduce on");
    property p_corr_pulse;
        corrStart[1] |=> !corrStart[1];
    endproperty
    a_corr_pulse: assert property (p_corr_pulse) else $error("long");
    property p_corr_red;
        corrStart[1] |-> !reduceOut[1];
    endproperty
    a_corr_red: assert property (p_corr_red) else $error("reduce");
    property p_corr_dist;
        corrStart[1] |-> corrDist[63:32] ==
            $past(cmdPos[63:32]) - $past(encPos[63:32]);
    endproperty
    a_corr_dist: assert property (p_corr_dist) else $error("dist");
    property p_wind_rst;
        $rose(rst_b) |-> windOff == '0;
    endproperty
    a_wind_rst: assert property (p_wind_rst) else $error("wind");

    // Main scenarios reached.
    c_corr: cover property (corrStart[1]);
    c_slverr: cover property (bvalid && bresp == `SCS_RESP_SLVERR);
    c_move: cover property (reduceOut[0] && moveStart[0]);
endmodule // scs_ctrl_checker

// *** verification/scs_drive_model.sv ***
/*
 * Behavioural stepper drive with a step generator: it answers a commanded
 * move or a correction with a single last-step pulse after a set delay.
 * Assumes moveStart and corrStart are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps

module scs_drive_model (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Move requests.
    input  wire logic [7:0] moveStart,
    input  wire logic [7:0] corrStart,
    // Pace: high gives long moves, low gives prompt ones.
    input  wire logic       slow,
    // End of motion.
    output logic      [7:0] lastStep
);
    // ------------------------------------------------------------------
    // Step counters.
    // ------------------------------------------------------------------
    int cnt [8];

    // A new request restarts the count, as a real generator would.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lastStep <= '0;
            for (int i = 0; i < 8; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                lastStep[i] <= (cnt[i] == 1);
                if (moveStart[i] || corrStart[i]) cnt[i] <= slow ? 40 : 3;
                else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule // scs_drive_model

// *** verification/testbench.sv ***
/*
 * Self-checking bench of the stepper control block against a model.
 * Assumes the drive model gives lastStep for each move and correction.
 */
`timescale 1ns/1ps
`include "scs_consts.svh"

module testbench;
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // Signals and model state.
    // ------------------------------------------------------------------
    logic         core_clk, rst_b, slow, seen;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready;
    scs_addr_t    awaddr, araddr;
    scs_word_t    wdata, rdata;
    logic [1:0]   bresp, rresp;
    logic [7:0]   moveStart, lastStep, reduceOut, windOff, corrStart;
    logic [255:0] cmdPos, encPos, corrDist;
    logic [7:0]   redM;
    scs_word_t    bandM [8];
    logic [15:0]  lfsrReg;
    int           mismatches, check_count, err, base;
    int           errTab [4] = '{6, -6, 5, -5};

    scs_ctrl scs_ctrl_i (.core_clk, .rst_b, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .moveStart, .lastStep, .cmdPos,
        .encPos, .reduceOut, .windOff, .corrStart, .corrDist);
    scs_drive_model scs_drive_model_i (.core_clk, .rst_b, .moveStart,
        .corrStart, .slow, .lastStep);

    // Free-running core clock, 100 ns period.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Watchdog: the whole run needs a few hundred cycles.
    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end

    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input scs_word_t seenVal, input scs_word_t expVal);
        check_count++;
        if (seenVal !== expVal) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seenVal, expVal);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Both bus tasks start on a fresh edge so no strobe is set twice.
    task automatic axi_wr(input logic [2:0] g, input int a,
                          input scs_word_t d, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= {g, a[2:0], 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check(scs_word_t'({bvalid, bresp}), scs_word_t'({1'b1, er}));
    endtask

    task automatic axi_rd(input logic [2:0] g, input int a,
                          input scs_word_t ed, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= {g, a[2:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check(rdata, ed);
        check(scs_word_t'({rvalid, rresp}), scs_word_t'({1'b1, er}));
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        moveStart = '0;
        cmdPos = '0;
        encPos = '0;
        slow = 1'b1;
        rst_b = 1'b0;
        mismatches = 0;
        check_count = 0;
        lfsrReg = 16'h003F;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        // Cleared settings, then random per-axis settings: reduce value in lane 1, band as a full word.
        for (int a = 0; a < 8; a++) begin
            axi_rd(`SCS_GRP_WIND, a, 32'h0, `SCS_RESP_OKAY);
            axi_rd(`SCS_GRP_BAND, a, 32'h0, `SCS_RESP_OKAY);
            lfsrReg = lfsr_step(lfsrReg);
            redM[a] = lfsrReg[2:0] != 3'h0;
            bandM[a] = {lfsrReg, ~lfsrReg};
            axi_wr(`SCS_GRP_REDUCE, a, {29'h0, lfsrReg[2:0]} << 8,
                   `SCS_RESP_OKAY);
            axi_wr(`SCS_GRP_BAND, a, bandM[a], `SCS_RESP_OKAY);
        end
        for (int a = 0; a < 8; a++) begin
            axi_rd(`SCS_GRP_REDUCE, a, 32'(redM[a]), `SCS_RESP_OKAY);
            axi_rd(`SCS_GRP_BAND, a, bandM[a], `SCS_RESP_OKAY);
        end
        @(negedge core_clk);
        check(32'(reduceOut), 32'(redM));
        axi_rd(3'h6, 0, 32'h0, `SCS_RESP_SLVERR);
        axi_wr(`SCS_GRP_STAT, 0, 32'h1, `SCS_RESP_SLVERR);
        // Axis 1 moves; windings-off written mid-move waits for idle.
        axi_wr(`SCS_GRP_REDUCE, 0, 32'h1, `SCS_RESP_OKAY);
        moveStart <= 8'h01;
        @(posedge core_clk);
        moveStart <= 8'h00;
        @(negedge core_clk);
        check(32'(reduceOut[0]), 32'h0);
        axi_wr(`SCS_GRP_WIND, 0, 32'h1, `SCS_RESP_OKAY);
        @(negedge core_clk);
        check(32'(windOff[0]), 32'h0);
        for (int n = 0; n < 60 && lastStep[0] !== 1'b1; n++)
            @(posedge core_clk);
        @(negedge core_clk);
        check(32'({windOff[0], reduceOut[0]}), 32'h3);
        axi_rd(`SCS_GRP_STAT, 0, 32'h6, `SCS_RESP_OKAY);
        axi_wr(`SCS_GRP_WIND, 0, 32'h0, `SCS_RESP_OKAY);
        axi_wr(`SCS_GRP_REDUCE, 0, 32'h0, `SCS_RESP_OKAY);
        @(negedge core_clk);
        check(32'({windOff[0], reduceOut[0]}), 32'h0);
        // Axis 2 closed loop: errors of both signs outside and on a band of 5.
        slow <= 1'b0;
        axi_wr(`SCS_GRP_BAND, 1, 32'h5, `SCS_RESP_OKAY);
        axi_wr(`SCS_GRP_LOOP, 1, 32'h1, `SCS_RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            err = errTab[k];
            lfsrReg = lfsr_step(lfsrReg);
            base = int'(lfsrReg);
            @(posedge core_clk);
            cmdPos[63:32] <= base;
            encPos[63:32] <= base - err;
            seen = 1'b0;
            for (int i = 0; i < 6 && !seen; i++) begin
                @(negedge core_clk);
                seen = corrStart[1] === 1'b1;
            end
            check(32'(seen), 32'(err > 5 || err < -5));
            if (seen) begin
                check(corrDist[63:32], 32'(err));
                check(32'(reduceOut[1]), 32'h0);
            end
            @(posedge core_clk);
            encPos[63:32] <= base;
            repeat (8) @(posedge core_clk);
        end
        finish_test();
    end
endmodule // testbench

bind scs_ctrl scs_ctrl_checker scs_ctrl_checker_i (.core_clk, .rst_b,
    .awready, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
    .rvalid, .rready, .rdata, .moveStart, .windOff, .cmdPos, .encPos,
    .reduceOut, .corrStart, .corrDist);
